// ===== pkg/fsc_pkg.sv
package fsc_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned SPINUP_MS       = 2000;
    localparam int unsigned SPINUP_CYC      = CLK_HZ / 1000 * SPINUP_MS;
    localparam int unsigned SAMPLE_FAST_MS  = 125;   // 8 updates per second
    localparam int unsigned SAMPLE_BASE_CYC = CLK_HZ / 1000 * SAMPLE_FAST_MS;
    localparam int unsigned PWM_SLOT_CYC    = 4;
    localparam logic [7:0]  PWM_SLOTS       = 8'hF0; // 240 slots
    localparam logic [7:0]  RPM_MIN_DUTY    = 8'hB4; // 180 slots, 75 percent
    localparam logic [7:0]  TACH_MAX        = 8'hFF;
    localparam logic [7:0]  DUTY_CODE_SLOTS = 8'h10; // 16 slots per speed code

    // register indexes, byte address is four times the index
    localparam logic [7:0] CFG1_IDX      = 8'h00;
    localparam logic [7:0] TACH_LIM_IDX  = 8'h10;
    localparam logic [7:0] SPEED_CFG_IDX = 8'h22;
    localparam logic [7:0] FILT_CFG_IDX  = 8'h23;
    localparam logic [7:0] STATUS_IDX    = 8'h24;
    localparam logic [7:0] DUTY_IDX      = 8'h25;

    // field positions
    localparam int unsigned CFG1_AUTO_BIT = 7;
    localparam int unsigned CFG1_RPM_BIT  = 5;
    localparam int unsigned SPEED_LSB     = 0;
    localparam int unsigned SPEED_W       = 4;

    // reset values
    localparam logic [7:0] CFG1_RST      = 8'h00;
    localparam logic [7:0] TACH_LIM_RST  = 8'hFF;
    localparam logic [7:0] SPEED_CFG_RST = 8'h00;
    localparam logic [7:0] FILT_CFG_RST  = 8'h10;

    // fan filter configuration layout
    typedef struct packed {
        logic       spin_dis;
        logic [1:0] ramp;
        logic [2:0] rate;
        logic       unused;
        logic       filt_en;
    } fsc_filt_s;

    // one-hot control modes
    typedef enum logic [2:0] {
        MODE_AUTO = 3'b001,
        MODE_DUTY = 3'b010,
        MODE_RPM  = 3'b100
    } fsc_mode_e;
endpackage : fsc_pkg

// ===== rtl/fsc_top.sv
// The APB slave port was chosen for this implementation.
module fsc_top #(
    parameter int unsigned SPINUP_CYC      = fsc_pkg::SPINUP_CYC,
    parameter int unsigned SAMPLE_BASE_CYC = fsc_pkg::SAMPLE_BASE_CYC,
    parameter int unsigned PWM_SLOT_CYC    = fsc_pkg::PWM_SLOT_CYC,
    parameter int unsigned ADDR_W          = 10
) (
    // clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic                   pready_o,
    output logic [31:0]            prdata_o,
    output logic                   pslverr_o,
    // temperature loop and tach measurement
    input  wire logic [7:0]        auto_duty_i,
    input  wire logic              tach_valid_i,
    input  wire logic [7:0]        tach_count_i,
    // fan side
    output logic                   pwm_o,
    output logic                   fan_fail_o
);

    // registers
    logic [7:0]         cfg1;
    logic [7:0]         tach_lim;
    logic [7:0]         speed_cfg;
    fsc_pkg::fsc_filt_s filt;
    // datapath state
    fsc_pkg::fsc_mode_e mode;
    logic [7:0]         duty;
    logic [7:0]         next_duty;
    logic [7:0]         prev_run_duty;
    logic [31:0]        smp_cnt;
    logic               smp_tick;
    logic [31:0]        spin_cnt;
    logic               spinning;
    logic               fail_q;
    logic [7:0]         slot_idx;
    logic [$clog2(PWM_SLOT_CYC+1)-1:0] slot_div;
    logic               wr_en;
    logic               rd_en;
    logic [7:0]         idx;
    logic               idx_hit;

    // mode from config1; automatic takes priority
    function automatic fsc_pkg::fsc_mode_e decode_mode(input logic [7:0] c);
        if (c[fsc_pkg::CFG1_AUTO_BIT]) begin
            return fsc_pkg::MODE_AUTO;
        end else if (c[fsc_pkg::CFG1_RPM_BIT]) begin
            return fsc_pkg::MODE_RPM;
        end
        return fsc_pkg::MODE_DUTY;
    endfunction : decode_mode

    // move cur toward tgt by step without overshoot
    function automatic logic [7:0] step_toward(input logic [7:0] cur,
                                               input logic [7:0] tgt,
                                               input logic [7:0] step);
        logic [8:0] up;
        up = {1'b0, cur} + {1'b0, step};
        if (tgt > cur) begin
            return (up > {1'b0, tgt}) ? tgt : up[7:0];
        end else if (tgt < cur) begin
            return (cur - tgt < step) ? tgt : cur - step;
        end
        return cur;
    endfunction : step_toward

    // clamp to a full period so duty never exceeds 100 percent
    function automatic logic [7:0] clamp_slots(input logic [7:0] v);
        return (v > fsc_pkg::PWM_SLOTS) ? fsc_pkg::PWM_SLOTS : v;
    endfunction : clamp_slots

    // speed code to slots; code 15 gives exactly a full period
    function automatic logic [7:0] code_to_slots(input logic [7:0] code);
        logic [11:0] prod;
        prod = 12'(code[fsc_pkg::SPEED_LSB +: fsc_pkg::SPEED_W]) * 12'(fsc_pkg::DUTY_CODE_SLOTS);
        return (prod > 12'(fsc_pkg::PWM_SLOTS)) ? fsc_pkg::PWM_SLOTS : prod[7:0];
    endfunction : code_to_slots

    // apb decode; one wait state so read data comes from a flop
    assign idx     = paddr_i[ADDR_W-1:2];
    assign idx_hit = (idx == fsc_pkg::CFG1_IDX) || (idx == fsc_pkg::TACH_LIM_IDX)
                  || (idx == fsc_pkg::SPEED_CFG_IDX) || (idx == fsc_pkg::FILT_CFG_IDX)
                  || (idx == fsc_pkg::STATUS_IDX) || (idx == fsc_pkg::DUTY_IDX);
    assign wr_en   = psel_i && penable_i && pready_o && pwrite_i && idx_hit;
    assign rd_en   = psel_i && penable_i && !pready_o && !pwrite_i;

    // bus handshake and read data
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && penable_i && !pready_o;
            pslverr_o <= psel_i && penable_i && !pready_o && !idx_hit;
            if (rd_en) begin
                case (idx)
                    fsc_pkg::CFG1_IDX:      prdata_o <= {24'h00_0000, cfg1};
                    fsc_pkg::TACH_LIM_IDX:  prdata_o <= {24'h00_0000, tach_lim};
                    fsc_pkg::SPEED_CFG_IDX: prdata_o <= {24'h00_0000, speed_cfg};
                    fsc_pkg::FILT_CFG_IDX:  prdata_o <= {24'h00_0000, filt};
                    fsc_pkg::STATUS_IDX:    prdata_o <= {29'h0000_0000, spinning,
                                                         mode == fsc_pkg::MODE_RPM,
                                                         fail_q};
                    fsc_pkg::DUTY_IDX:      prdata_o <= {24'h00_0000, duty};
                    default:                prdata_o <= 32'h0000_0000;
                endcase
            end else if (!(psel_i && penable_i)) begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    // software registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg1      <= fsc_pkg::CFG1_RST;
            tach_lim  <= fsc_pkg::TACH_LIM_RST;
            speed_cfg <= fsc_pkg::SPEED_CFG_RST;
            filt      <= fsc_pkg::FILT_CFG_RST;
        end else if (wr_en) begin
            case (idx)
                fsc_pkg::CFG1_IDX:      cfg1 <= pwdata_i[7:0];
                fsc_pkg::TACH_LIM_IDX:  tach_lim <= pwdata_i[7:0];
                fsc_pkg::SPEED_CFG_IDX: speed_cfg <= pwdata_i[7:0];
                fsc_pkg::FILT_CFG_IDX: begin
                    filt         <= fsc_pkg::fsc_filt_s'(pwdata_i[7:0]);
                    filt.unused  <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode <= fsc_pkg::MODE_DUTY;
        end else begin
            mode <= decode_mode(cfg1);
        end
    end

    // sample tick; period 16 s at code 0 halving per code
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            smp_cnt  <= 32'h0000_0000;
            smp_tick <= 1'b0;
        end else if (smp_cnt >= (32'(SAMPLE_BASE_CYC) << (3'h7 - filt.rate)) - 32'h1) begin
            smp_cnt  <= 32'h0000_0000;
            smp_tick <= 1'b1;
        end else begin
            smp_cnt  <= smp_cnt + 32'h1;
            smp_tick <= 1'b0;
        end
    end

    // duty target per mode
    always_comb begin
        next_duty = duty;
        case (mode)
            fsc_pkg::MODE_AUTO: begin
                if (smp_tick) begin
                    if (filt.filt_en) begin
                        // step of 1 shl ramp slots
                        next_duty = step_toward(duty, clamp_slots(auto_duty_i),
                                                8'h01 << filt.ramp);
                    end else begin
                        next_duty = clamp_slots(auto_duty_i);
                    end
                end
            end
            fsc_pkg::MODE_DUTY: begin
                // sixteen slots per code; 0x08 is 128/240
                next_duty = clamp_slots(code_to_slots(speed_cfg));
            end
            fsc_pkg::MODE_RPM: begin
                // larger count means slower fan, raise duty
                if (tach_valid_i) begin
                    if (tach_count_i > tach_lim) begin
                        next_duty = step_toward(duty, fsc_pkg::PWM_SLOTS, 8'h01);
                    end else if (tach_count_i < tach_lim) begin
                        next_duty = step_toward(duty, fsc_pkg::RPM_MIN_DUTY, 8'h01);
                    end
                end
                if (next_duty < fsc_pkg::RPM_MIN_DUTY) begin
                    next_duty = fsc_pkg::RPM_MIN_DUTY;
                end
            end
            default: next_duty = duty;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            duty          <= 8'h00;
            prev_run_duty <= 8'h00;
        end else begin
            duty          <= next_duty;
            prev_run_duty <= duty;
        end
    end

    // fail only at full-scale count, level until a good reading
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fail_q     <= 1'b0;
            fan_fail_o <= 1'b0;
        end else if (tach_valid_i) begin
            fail_q     <= (tach_count_i == fsc_pkg::TACH_MAX);
            fan_fail_o <= (tach_count_i == fsc_pkg::TACH_MAX);
        end
    end

    // spin-up on start from zero or on a new failure
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            spin_cnt <= 32'h0000_0000;
            spinning <= 1'b0;
        end else if (!filt.spin_dis && duty != 8'h00
                     && (prev_run_duty == 8'h00
                         || (tach_valid_i && tach_count_i == fsc_pkg::TACH_MAX && !fail_q))) begin
            spin_cnt <= 32'(SPINUP_CYC) - 32'h1;
            spinning <= 1'b1;
        end else if (spin_cnt != 32'h0000_0000) begin
            spin_cnt <= spin_cnt - 32'h1;
        end else begin
            spinning <= 1'b0;
        end
    end

    // slot counter, 240 slots per period
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            slot_div <= '0;
            slot_idx <= 8'h00;
        end else if (slot_div == ($bits(slot_div))'(PWM_SLOT_CYC - 1)) begin
            slot_div <= '0;
            slot_idx <= (slot_idx == fsc_pkg::PWM_SLOTS - 8'h01) ? 8'h00 : slot_idx + 8'h01;
        end else begin
            slot_div <= slot_div + ($bits(slot_div))'(1);
        end
    end

    // pwm output; spin-up forces full drive
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwm_o <= 1'b0;
        end else begin
            pwm_o <= spinning || (slot_idx < duty);
        end
    end

endmodule : fsc_top

// ===== verif/fan_speed_control_modes_tb_top.sv
module fan_speed_control_modes_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
    logic        tach_valid_i, pwm_o, fan_fail_o;
    logic [9:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, r;
    logic [7:0]  auto_duty_i, tach_count_i, fan_cnt;
    logic [15:0] rows [16];
    int          failures, total_checks, hi;

    fsc_top #(.SPINUP_CYC(50), .SAMPLE_BASE_CYC(8)) u_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
        .prdata_o(prdata_o), .pslverr_o(pslverr_o), .auto_duty_i(auto_duty_i),
        .tach_valid_i(tach_valid_i), .tach_count_i(tach_count_i), .pwm_o(pwm_o),
        .fan_fail_o(fan_fail_o));
    fsc_fan_model u_fan (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pwm_i(pwm_o),
        .count_i(fan_cnt), .tach_valid_o(tach_valid_i), .tach_count_o(tach_count_i));

    // 10 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; pready is read as sampled at the edge, watchdog bounds the wait
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge sys_clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= {idx, 2'b00};
        pwdata_i  <= {24'h0, d};
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(r, exp);
    endtask : rdc

    task automatic summarize();
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // watchdog
    initial begin
        repeat (90000) @(posedge sys_clk_i);
        failures++;
        summarize();
    end

    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        auto_duty_i = 8'h60;
        fan_cnt = 8'h40;
        rst_i = 1'b1;
        failures = 0;
        total_checks = 0;
        // rows: speed code beside its duty in slots
        foreach (rows[i]) rows[i] = {8'(i), (i == 15) ? 8'hF0 : 8'(i * 16)};
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdc(fsc_pkg::CFG1_IDX, 32'h00);
        rdc(fsc_pkg::TACH_LIM_IDX, 32'hFF);
        rdc(fsc_pkg::FILT_CFG_IDX, 32'h10);
        rdc(8'h01, 32'h00);
        check({31'h0, e}, 32'h1);
        apb(1'b1, fsc_pkg::FILT_CFG_IDX, 8'hE3);
        rdc(fsc_pkg::FILT_CFG_IDX, 32'hE1);
        // start from zero duty with boost disabled
        apb(1'b1, fsc_pkg::SPEED_CFG_IDX, 8'h01);
        apb(1'b0, fsc_pkg::STATUS_IDX, 8'h00);
        check(r & 32'h4, 32'h0);
        // filter on and spin-up off: neither may touch direct duty
        foreach (rows[i]) begin
            apb(1'b1, fsc_pkg::SPEED_CFG_IDX, rows[i][15:8]);
            repeat (1100) @(posedge sys_clk_i);
            rdc(fsc_pkg::DUTY_IDX, {24'h0, rows[i][7:0]});
            hi = 0;
            repeat (240 * fsc_pkg::PWM_SLOT_CYC) begin
                @(negedge sys_clk_i);
                hi += int'(pwm_o === 1'b1);
            end
            check(32'(hi), 32'(rows[i][7:0]) * fsc_pkg::PWM_SLOT_CYC);
        end
        apb(1'b1, fsc_pkg::CFG1_IDX, 8'h20);
        apb(1'b1, fsc_pkg::TACH_LIM_IDX, 8'h40);
        fan_cnt <= 8'h20;
        repeat (14000) @(posedge sys_clk_i);
        rdc(fsc_pkg::DUTY_IDX, 32'hB4);
        apb(1'b0, fsc_pkg::STATUS_IDX, 8'h00);
        check(r & 32'h2, 32'h2);
        fan_cnt <= 8'h80;
        repeat (14000) @(posedge sys_clk_i);
        rdc(fsc_pkg::DUTY_IDX, 32'hF0);
        fan_cnt <= 8'hFF;
        repeat (400) @(posedge sys_clk_i);
        check({31'h0, fan_fail_o}, 32'h1);
        fan_cnt <= 8'h20;
        repeat (400) @(posedge sys_clk_i);
        check({31'h0, fan_fail_o}, 32'h0);
        // automatic mode wins over bit 5, filtered ramp of one slot
        // filter set before auto
        apb(1'b1, fsc_pkg::FILT_CFG_IDX, 8'h9D);
        apb(1'b1, fsc_pkg::CFG1_IDX, 8'hA0);
        // a jump would already sit at the target here
        repeat (80) @(posedge sys_clk_i);
        apb(1'b0, fsc_pkg::DUTY_IDX, 8'h00);
        check({31'h0, r[7:0] > 8'h60}, 32'h1);
        repeat (2000) @(posedge sys_clk_i);
        rdc(fsc_pkg::DUTY_IDX, 32'h60);
        apb(1'b0, fsc_pkg::STATUS_IDX, 8'h00);
        check(r & 32'h2, 32'h0);
        // second reset mid-run
        rst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdc(fsc_pkg::FILT_CFG_IDX, 32'h10);
        // restart from zero duty with boost enabled
        apb(1'b1, fsc_pkg::SPEED_CFG_IDX, 8'h01);
        apb(1'b0, fsc_pkg::STATUS_IDX, 8'h00);
        check(r & 32'h4, 32'h4);
        hi = 0;
        repeat (30) begin
            @(negedge sys_clk_i);
            hi += int'(pwm_o === 1'b1);
        end
        check(32'(hi), 32'h1E);
        repeat (60) @(posedge sys_clk_i);
        apb(1'b0, fsc_pkg::STATUS_IDX, 8'h00);
        check(r & 32'h4, 32'h0);
        summarize();
    end
endmodule : fan_speed_control_modes_tb_top

// ===== verif/fsc_assertions.sv
module fsc_assertions #(
    parameter int unsigned ADDR_W = 10
) (
    // clock and reset
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    // apb
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic              pready_o,
    input wire logic [31:0]       prdata_o,
    input wire logic              pslverr_o,
    // tach and fan
    input wire logic              tach_valid_i,
    input wire logic [7:0]        tach_count_i,
    input wire logic              fan_fail_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // completed access and its register index
    logic       done;
    logic [7:0] idx;
    assign done = psel_i && penable_i && pready_o;
    assign idx  = paddr_i[9:2];

    AST_RDY_AFTER_ONE: assert property ($rose(penable_i) && psel_i |=> pready_o)
        else $error("ready late");
    AST_RDY_ONE_CYC: assert property (pready_o |=> !pready_o)
        else $error("ready held");
    AST_ERR_WITH_RDY: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    AST_UNMAPPED: assert property (done && !(idx inside {8'h00, 8'h10, [8'h22:8'h25]})
        |-> pslverr_o && prdata_o == 32'h0) else $error("unmapped not refused");
    AST_FILT_BIT1: assert property (
        done && !pwrite_i && idx == 8'h23 |-> !prdata_o[1]) else $error("unused bit set");
    AST_FAIL_SET: assert property (
        tach_valid_i && tach_count_i == 8'hFF |=> fan_fail_o) else $error("fail missed");
    AST_FAIL_CLR: assert property (
        tach_valid_i && tach_count_i != 8'hFF |=> !fan_fail_o) else $error("fail false");
    AST_FAIL_HOLD: assert property (
        !tach_valid_i |=> $stable(fan_fail_o)) else $error("fail moved");
endmodule : fsc_assertions

bind fsc_top fsc_assertions #(.ADDR_W(ADDR_W)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .tach_valid_i(tach_valid_i), .tach_count_i(tach_count_i),
    .fan_fail_o(fan_fail_o));

// ===== verif/fsc_fan_model.sv
module fsc_fan_model #(
    parameter int unsigned GAP = 200
) (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // drive and wanted count
    input  wire logic       pwm_i,
    input  wire logic [7:0] count_i,
    // measurement
    output logic            tach_valid_o,
    output logic [7:0]      tach_count_o
);
    int unsigned gap_q;
    logic        ran_q;
    // a window with no drive reads as stalled; stale count inverts
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap_q        <= 0;
            ran_q        <= 1'b0;
            tach_valid_o <= 1'b0;
            tach_count_o <= 8'h00;
        end else begin
            gap_q        <= (gap_q == GAP - 1) ? 0 : gap_q + 1;
            ran_q        <= (gap_q == GAP - 1) ? 1'b0 : (ran_q | pwm_i);
            tach_valid_o <= (gap_q == GAP - 1);
            tach_count_o <= (gap_q == GAP - 1) ? (ran_q ? count_i : 8'hFF) : ~tach_count_o;
        end
    end
endmodule : fsc_fan_model
